/* File: sgd_pkg.sv */
// Package for the serial gain/delay configuration write host.
// Assumes a single 200 MHz clock domain in the host.
package sgd_pkg;
	localparam int          SGD_WORD_BITS   = 7;
	localparam int          SGD_EDGES       = 14;
	localparam int          SGD_CLK_NS      = 5;
	// Interval minima in ns; device timing not given here, so plain defaults
	localparam int          SGD_SETUP_NS    = 50;
	localparam int          SGD_DATA_NS     = 100;
	localparam int          SGD_STRB_HI_NS  = 100;
	localparam int          SGD_HOLD_NS     = 100;
	localparam int          SGD_IDLE_NS     = 200;
	localparam int          SGD_SETUP_CYC   = (SGD_SETUP_NS + SGD_CLK_NS - 1) / SGD_CLK_NS;
	localparam int          SGD_DATA_CYC    = (SGD_DATA_NS + SGD_CLK_NS - 1) / SGD_CLK_NS;
	localparam int          SGD_STRB_HI_CYC = (SGD_STRB_HI_NS + SGD_CLK_NS - 1) / SGD_CLK_NS;
	localparam int          SGD_HOLD_CYC    = (SGD_HOLD_NS + SGD_CLK_NS - 1) / SGD_CLK_NS;
	localparam int          SGD_IDLE_CYC    = (SGD_IDLE_NS + SGD_CLK_NS - 1) / SGD_CLK_NS;
	localparam int          SGD_CNT_W       = 8;

	typedef enum logic [2:0]
	{
		SGD_IDLE  = 3'b000,
		SGD_SETUP = 3'b001,
		SGD_LOW   = 3'b010,
		SGD_HIGH  = 3'b011,
		SGD_HOLD  = 3'b100,
		SGD_REST  = 3'b101
	} sgd_state_e;
endpackage

/* File: sgd_host.sv */
// Host that writes a seven-bit configuration word over select/strobe/data pins.
// Assumes i_word and i_start come from the i_mclk domain; pins go to the device.
`timescale 1ns/1ps

module sgd_host
	import sgd_pkg::*;
(
	input  wire logic                     i_mclk,
	input  wire logic                     i_rst_n,
	input  wire logic                     i_start,
	input  wire logic [SGD_WORD_BITS-1:0] i_word,
	output logic                          o_busy,
	output logic                          o_done,
	output logic                          o_select_n,
	output logic                          o_write_strobe_n,
	output logic                          o_sdata
);
	sgd_state_e                state;
	sgd_state_e                next_state;
	logic [SGD_CNT_W-1:0]      cnt;
	logic [SGD_CNT_W-1:0]      next_cnt;
	logic [SGD_WORD_BITS-1:0]  shreg;
	logic [3:0]                edges;
	logic [3:0]                next_edges;

	wire cnt_zero   = (cnt == '0);
	wire last_bit   = (edges == 4'(SGD_EDGES - 1));
	wire take_start = (state == SGD_IDLE) && i_start;

	// Timers load one less than the count so each phase lasts exactly that many cycles
	always_comb
	begin
		next_state = state;
		next_cnt   = cnt_zero ? cnt : cnt - 8'h01;
		next_edges = edges;
		case (state)
			SGD_IDLE:
			begin
				if (i_start)
				begin
					next_state = SGD_SETUP;
					next_cnt   = SGD_CNT_W'(SGD_SETUP_CYC - 1);
					next_edges = 4'h0;
				end
			end
			SGD_SETUP:
			begin
				if (cnt_zero)
				begin
					next_state = SGD_LOW;
					next_cnt   = SGD_CNT_W'(SGD_DATA_CYC - 1);
					next_edges = edges + 4'h1;
				end
			end
			SGD_LOW:
			begin
				if (cnt_zero)
				begin
					next_edges = edges + 4'h1;
					if (last_bit)
					begin
						next_state = SGD_HOLD;
						next_cnt   = SGD_CNT_W'(SGD_HOLD_CYC - 1);
					end
					else
					begin
						next_state = SGD_HIGH;
						next_cnt   = SGD_CNT_W'(SGD_STRB_HI_CYC - 1);
					end
				end
			end
			SGD_HIGH:
			begin
				if (cnt_zero)
				begin
					next_state = SGD_SETUP;
					next_cnt   = SGD_CNT_W'(SGD_SETUP_CYC - 1);
				end
			end
			SGD_HOLD:
			begin
				if (cnt_zero)
				begin
					next_state = SGD_REST;
					next_cnt   = SGD_CNT_W'(SGD_IDLE_CYC - 1);
				end
			end
			SGD_REST:
			begin
				if (cnt_zero)
					next_state = SGD_IDLE;
			end
			default:
				next_state = SGD_IDLE;
		endcase
	end

	// Advance data only when the strobe high gap ends, never on the rising edge
	// itself: the device captures on that edge, so the old bit must still stand
	wire bit_advance = (state == SGD_HIGH) && cnt_zero;
	wire [SGD_WORD_BITS-1:0] next_shreg = take_start ? i_word :
		bit_advance ? (shreg >> 1) : shreg;

	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			state <= SGD_IDLE;
			cnt   <= '0;
			edges <= '0;
			shreg <= '0;
		end
		else
		begin
			state <= next_state;
			cnt   <= next_cnt;
			edges <= next_edges;
			shreg <= next_shreg;
		end
	end

	// Registered pins; derived from next state (o_done from the SGD_HOLD exit condition) to avoid a cycle of lag
	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_select_n       <= 1'b1;
			o_write_strobe_n <= 1'b1;
			o_sdata          <= 1'b0;
			o_busy           <= 1'b0;
			o_done           <= 1'b0;
		end
		else
		begin
			o_select_n       <= (next_state == SGD_IDLE) || (next_state == SGD_REST);
			o_write_strobe_n <= (next_state != SGD_LOW);
			o_sdata          <= next_shreg[0];
			o_busy           <= (next_state != SGD_IDLE);
			o_done           <= (state == SGD_HOLD) && cnt_zero;
		end
	end

	// Helper counter of rising strobe edges inside one select window
	logic [3:0] rise_cnt;
	logic       strb_d;
	// Bit age saturates at 15; setup only needs a floor
	logic       sdata_d;
	logic [3:0] data_age;
	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			rise_cnt <= '0;
			strb_d   <= 1'b1;
			sdata_d  <= 1'b0;
			data_age <= '0;
		end
		else
		begin
			strb_d   <= o_write_strobe_n;
			sdata_d  <= o_sdata;
			data_age <= (o_sdata != sdata_d) ? 4'h0 :
				(data_age == 4'hf) ? data_age : data_age + 4'h1;
			rise_cnt <= o_select_n ? 4'h0 :
				(o_write_strobe_n && !strb_d) ? rise_cnt + 4'h1 : rise_cnt;
		end
	end

	seven_rises_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		$rose(o_select_n) |-> $past(rise_cnt) == 4'h7)
		else $error("Write cycle did not have seven rising strobes");
	no_extra_rise_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		rise_cnt <= 4'h7)
		else $error("More than seven strobe pulses in a cycle");
	strobe_in_sel_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		!o_write_strobe_n |-> !o_select_n)
		else $error("Strobe low while select released");
	data_stable_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		!o_write_strobe_n && $past(!o_write_strobe_n) |-> $stable(o_sdata))
		else $error("Data changed while strobe low");
	low_width_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		$fell(o_write_strobe_n) |-> !o_write_strobe_n [*8])
		else $error("Strobe low too short");
	high_gap_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		$rose(o_write_strobe_n) && !o_select_n |-> o_write_strobe_n [*8])
		else $error("Strobe high gap too short");
	sel_hold_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		$rose(o_select_n) |-> $past(o_write_strobe_n, 2) && $past(!o_select_n, 2))
		else $error("Select released too soon after strobe");
	idle_gap_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		$rose(o_select_n) |-> o_select_n [*8])
		else $error("Select idle time too short");
	lsb_first_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		take_start ##1 1 |-> o_sdata == $past(i_word[0]))
		else $error("First bit not the least significant");
	data_hold_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		$rose(o_write_strobe_n) |-> $stable(o_sdata))
		else $error("Data changed at rising strobe");
	data_setup_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		$fell(o_write_strobe_n) |-> data_age >= 4'h8)
		else $error("Data not settled before strobe fell");

	cyc_cover_c:  cover property (@(posedge i_mclk) disable iff (!i_rst_n) $rose(o_select_n));
	start_cover_c: cover property (@(posedge i_mclk) disable iff (!i_rst_n) take_start);
	busy_start_c: cover property (@(posedge i_mclk) disable iff (!i_rst_n) o_busy && i_start);
	b2b_cover_c:  cover property (@(posedge i_mclk) disable iff (!i_rst_n)
		o_done ##[1:100] take_start);
endmodule

/* File: sgd_dev_model.sv */
// Device model: shifts strobed bits in, applies word when select releases.
// Assumes host pins only; the device has no clock of its own.
`timescale 1ns/1ps
module sgd_dev_model
	import sgd_pkg::*;
(
	input  wire logic                     i_select_n,
	input  wire logic                     i_write_strobe_n,
	input  wire logic                     i_sdata,
	output logic [SGD_WORD_BITS-1:0]      o_word,
	output logic [3:0]                    o_rises
);
	logic [SGD_WORD_BITS-1:0] shift = '0;
	initial o_word = '0;
	initial o_rises = 4'h0;
	always @(negedge i_select_n) o_rises = 4'h0;
	// First bit in is the LSB, so shift toward bit 0
	always @(posedge i_write_strobe_n)
	begin
		if (!i_select_n)
		begin
			shift = {i_sdata, shift[SGD_WORD_BITS-1:1]};
			o_rises = o_rises + 4'h1;
		end
	end
	always @(posedge i_select_n) o_word = shift;
endmodule

/* File: tb.sv */
// Testbench for the serial configuration write host.
// Assumes the device model on the pins; one 200 MHz clock.
`timescale 1ns/1ps
module tb
	import sgd_pkg::*;
;
	logic                     i_mclk = 1'b0;
	logic                     i_rst_n;
	logic                     i_start;
	logic [SGD_WORD_BITS-1:0] i_word;
	logic                     o_busy, o_done, o_select_n, o_write_strobe_n, o_sdata;
	logic [SGD_WORD_BITS-1:0] dev_word;
	logic [3:0]               dev_rises;
	logic                     ps = 1'b1;
	logic                     pd = 1'b0;
	logic                     psel = 1'b1;
	int                       run, held;
	int                       falls, bad, fails, samples_checked;
	logic [SGD_WORD_BITS-1:0] corner [6] = '{7'h00, 7'h7f, 7'h01, 7'h40, 7'h55, 7'h2a};

	always #2.5 i_mclk = ~i_mclk;

	sgd_host sgd_host_inst (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_start(i_start),
		.i_word(i_word), .o_busy(o_busy), .o_done(o_done), .o_select_n(o_select_n),
		.o_write_strobe_n(o_write_strobe_n), .o_sdata(o_sdata));
	sgd_dev_model sgd_dev_model_inst (.i_select_n(o_select_n),
		.i_write_strobe_n(o_write_strobe_n), .i_sdata(o_sdata), .o_word(dev_word),
		.o_rises(dev_rises));

	// Pin monitor at the falling edge, where the pins have settled
	// Data may move only while the strobe was and stays high
	always @(negedge i_mclk)
	begin
		if (ps && !o_write_strobe_n) falls++;
		if (ps != o_write_strobe_n && o_select_n) bad++;
		if ((!ps || !o_write_strobe_n) && pd != o_sdata) bad++;
		if (o_select_n && !psel) held = run;
		run = (o_select_n || !o_write_strobe_n) ? 0 : run + 1;
		ps <= o_write_strobe_n;
		pd <= o_sdata;
		psel <= o_select_n;
	end

	function automatic logic [7:0] exp_toggles();
		return 8'(2 * SGD_WORD_BITS);
	endfunction

	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e)
		begin
			fails++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic summarize();
		$display("checked %0d failed %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// A second start mid-cycle must be ignored, so the word stays w
	task automatic wr(input logic [SGD_WORD_BITS-1:0] w);
		int dn;
		dn = 0;
		falls = 0;
		bad = 0;
		i_start = 1'b1;
		i_word = w;
		@(negedge i_mclk);
		i_start = 1'b0;
		@(negedge i_mclk);
		for (int i = 0; i < 2000 && o_busy === 1'b1; i++)
		begin
			i_start = (i == 40);
			i_word = (i == 40) ? ~w : w;
			@(negedge i_mclk);
			if (o_done === 1'b1) dn++;
		end
		chk("busy", 8'h00, {7'h0, o_busy});
		chk("word", {1'b0, w}, {1'b0, dev_word});
		chk("rises", 8'h07, {4'h0, dev_rises});
		chk("toggles", exp_toggles(), 8'(falls) + {4'h0, dev_rises});
		chk("done", 8'h01, 8'(dn));
		chk("hold", 8'(SGD_HOLD_CYC), 8'(held));
		chk("pin order", 8'h00, 8'(bad));
	endtask

	initial
	begin
		i_rst_n = 1'b0;
		i_start = 1'b0;
		i_word = '0;
		void'($urandom(32'hb27a));
		repeat (3) @(posedge i_mclk);
		chk("reset select", 8'h01, {7'h0, o_select_n});
		@(negedge i_mclk);
		i_rst_n = 1'b1;
		foreach (corner[k]) wr(corner[k]);
		repeat (8) wr(7'($urandom));
		summarize();
	end

	initial
	begin
		repeat (20000) @(posedge i_mclk);
		fails++;
		summarize();
	end
endmodule
